/* hdl/single_wire_gauge_register_port.sv */
// single-wire serial register port and primary flag logic of the gauge
// What this block does
// - line is open-drain; device only pulls low or releases, host pulls up
// - host command byte, then eight bits stored or eight bits returned
// - bit rate never above 333 bits per second either way
// - bytes travel least significant bit first
// - long low is a break; device then awaits a command
// - each bit frame opens with the sender pulling low for start time
// - bit value valid by setup time after fall, held for valid time
// - sender releases by stop setup time and stays high to frame end
// - command word loads after eight bits and cannot be read back
// - command bit 7 low reads, high means eight data bits follow
// - low seven bits address; writes to non-writable addresses are dropped
// - primary flags at 01h, bits 7..0 as listed, bit 2 unused
// - charge_active follows sense above threshold, cleared by discharge
// - battery_swapped set by cell crossings or reset, cleared by charge
// - battery_absent set while cell above 2.25V or below 0.1V
// - battery_absent filtered, reacting within 30 seconds
// - capacity_stale set on 64th valid charge or reset, cleared on update
// - valid_discharge set from full, cleared by update and three causes
// - first empty warning latched until a valid charge
// - final warning 100mV lower, latched, blanks display, floats empty
`timescale 1ns/1ps
module single_wire_gauge_register_port #(
   parameter int CW        = 20,
   parameter int BIT_CYC   = gauge_port_pkg::BIT_CYC,
   parameter int START_CYC = gauge_port_pkg::START_CYC,
   parameter int DSU_CYC   = gauge_port_pkg::DSU_CYC,
   parameter int DV_CYC    = gauge_port_pkg::DV_CYC,
   parameter int SSU_CYC   = gauge_port_pkg::SSU_CYC,
   parameter int BREAK_CYC = gauge_port_pkg::BREAK_CYC,
   parameter int BR_CYC    = gauge_port_pkg::BR_CYC,
   parameter int GAP_CYC   = gauge_port_pkg::GAP_CYC,
   parameter int MS_CYC    = gauge_port_pkg::MS_CYC,
   parameter int ABSENT_MS = gauge_port_pkg::ABSENT_MS
) (
   // clock and reset
   input  wire logic                  REF_CLK_I,
   input  wire logic                  RST_N_I,
   // serial line, open drain
   input  wire logic                  DQ_I,
   output logic                       DQ_O,
   output logic                       DQ_OE_O,
   // gauge core side
   input  wire gauge_port_pkg::meas_t MEAS_I,
   input  wire gauge_port_pkg::ev_t   EV_I,
   output gauge_port_pkg::regs_t      REGS_O,
   output logic [7:0]                 FLAGS_O,
   output logic [7:0]                 CPI_O,
   output logic                       SOFT_RESET_O,
   output logic                       DISPLAY_OFF_O,
   output logic                       EMPTY_FLOAT_O
);
   typedef enum logic [1:0] {L_IDLE, L_LOW, L_GAP, L_TX} link_t;

   localparam logic [CW-1:0] C_BIT   = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] C_START = CW'(START_CYC);
   localparam logic [CW-1:0] C_DSU   = CW'(DSU_CYC);
   localparam logic [CW-1:0] C_DV    = CW'(DV_CYC);
   localparam logic [CW-1:0] C_SSU   = CW'(SSU_CYC);
   localparam logic [CW-1:0] C_BRK   = CW'(BREAK_CYC);
   localparam logic [CW-1:0] C_BR    = CW'(BR_CYC);
   localparam logic [CW-1:0] C_GAP   = CW'(GAP_CYC);
   localparam logic [CW-1:0] C_MAX   = '1;

   logic                  s1_ff;
   logic                  s2_ff;
   logic                  prev_ff;
   link_t                 st_ff;
   logic [CW-1:0]         cnt_ff;
   logic [2:0]            bit_ff;
   logic [7:0]            sh_ff;
   logic                  data_ph_ff;
   logic                  brk_ff;
   logic [7:0]            cmd_ff;
   logic [7:0]            tx_ff;
   logic                  oe_ff;
   logic                  zero_ff;
   gauge_port_pkg::regs_t regs_ff;
   logic [7:0]            cpi_ff;
   logic                  chg_ff;
   logic                  swap_ff;
   logic                  abs_ff;
   logic                  stale_ff;
   logic                  vdq_ff;
   logic                  from_full_ff;
   logic                  first_empty_warning_ff;
   logic                  final_empty_warning_ff;
   logic                  srst_ff;
   logic                  hi_ff;
   logic                  lo_ff;
   logic [17:0]           ms_ff;
   logic [15:0]           flt_ff;

   logic                  fall;
   logic                  rise;
   logic                  rx_bit;
   logic [7:0]            nxt_byte;
   logic                  is_break;
   logic                  byte_done;
   logic                  wr_en;
   logic [6:0]            wr_addr;
   logic [7:0]            rd_data;
   logic [7:0]            flags;
   logic                  raw_abs;
   logic [7:0]            vts_f;

   // ==========================================================
   // line input: two flops before anything looks at it
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         s1_ff   <= 1'b1;
         s2_ff   <= 1'b1;
         prev_ff <= 1'b1;
      end else begin
         s1_ff   <= DQ_I;
         s2_ff   <= s1_ff;
         prev_ff <= s2_ff;
      end
   end

   assign fall      = prev_ff & ~s2_ff;
   assign rise      = ~prev_ff & s2_ff;
   assign is_break  = (cnt_ff >= C_BRK);
   assign rx_bit    = (cnt_ff < C_DSU);                  // short low reads as one
   assign nxt_byte  = {rx_bit, sh_ff[7:1]};              // lsb arrives first
   assign byte_done = (st_ff == L_LOW) && rise && !is_break && (bit_ff == 3'h7);
   assign wr_en     = byte_done && data_ph_ff;
   assign wr_addr   = cmd_ff[6:0];

   // ==========================================================
   // link sequencer: receive by low width, answer reads after a gap
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         st_ff      <= L_IDLE;
         cnt_ff     <= '0;
         bit_ff     <= 3'h0;
         sh_ff      <= 8'h00;
         data_ph_ff <= 1'b0;
         brk_ff     <= 1'b0;
         cmd_ff     <= 8'h00;
         tx_ff      <= 8'h00;
      end else begin
         case (st_ff)
            L_IDLE: begin
               cnt_ff <= (cnt_ff == C_MAX) ? cnt_ff : cnt_ff + 1'b1;
               // a fall too soon after a break is not a frame
               if (fall && !(brk_ff && cnt_ff < C_BR)) begin
                  st_ff  <= L_LOW;
                  cnt_ff <= '0;
               end
            end
            L_LOW: begin
               cnt_ff <= (cnt_ff == C_MAX) ? cnt_ff : cnt_ff + 1'b1;
               if (rise) begin
                  st_ff  <= L_IDLE;
                  cnt_ff <= '0;
                  if (is_break) begin
                     // partial byte dropped, next byte is a command
                     bit_ff     <= 3'h0;
                     data_ph_ff <= 1'b0;
                     brk_ff     <= 1'b1;
                  end else begin
                     brk_ff <= 1'b0;
                     sh_ff  <= nxt_byte;
                     bit_ff <= bit_ff + 3'h1;
                     if (bit_ff == 3'h7) begin
                        if (data_ph_ff) begin
                           data_ph_ff <= 1'b0;
                        end else begin
                           cmd_ff <= nxt_byte;
                           if (nxt_byte[gauge_port_pkg::DIR_BIT]) begin
                              data_ph_ff <= 1'b1;
                           end else begin
                              st_ff <= L_GAP;
                              tx_ff <= rd_data;
                           end
                        end
                     end
                  end
               end
            end
            L_GAP: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == C_GAP) begin
                  st_ff  <= L_TX;
                  cnt_ff <= '0;
               end
            end
            L_TX: begin
               cnt_ff <= cnt_ff + 1'b1;
               // one frame per bit period keeps the rate legal
               if (cnt_ff == C_BIT) begin
                  cnt_ff <= '0;
                  tx_ff  <= {1'b0, tx_ff[7:1]};
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     st_ff <= L_IDLE;
                  end
               end
            end
            default: begin
               st_ff <= L_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // driver: start low, hold low through valid time for a zero
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         oe_ff   <= 1'b0;
         zero_ff <= 1'b0;
      end else begin
         zero_ff <= 1'b0;                                   // only ever pulls low
         oe_ff   <= (st_ff == L_TX) && cnt_ff != C_BIT
                    && ((cnt_ff < C_START)
                    || (!tx_ff[0] && cnt_ff < C_DV));
      end
   end

   // ==========================================================
   // read mux; command word and reset register read as zero
   always_comb begin
      // decoded from the byte just completing, before cmd_ff loads
      case (nxt_byte[6:0])
         gauge_port_pkg::A_FLAGS: rd_data = flags;
         gauge_port_pkg::A_TEMPERATURE_AND_GAUGE: rd_data = MEAS_I.temperature_and_gauge;
         gauge_port_pkg::A_CHARGE_COUNT_HIGH:  rd_data = regs_ff.charge_count_high;
         gauge_port_pkg::A_BATTERY_IDENT: rd_data = regs_ff.battery_ident;
         gauge_port_pkg::A_LMD:   rd_data = regs_ff.learned_capacity;
         gauge_port_pkg::A_SECONDARY_FLAGS: rd_data = MEAS_I.secondary_flags;
         gauge_port_pkg::A_PPD:   rd_data = MEAS_I.prog_pin_pulldown;
         gauge_port_pkg::A_PPU:   rd_data = MEAS_I.prog_pin_pullup;
         gauge_port_pkg::A_CPI:   rd_data = cpi_ff;
         gauge_port_pkg::A_DMF:   rd_data = regs_ff.filter_threshold;
         gauge_port_pkg::A_VSB:   rd_data = MEAS_I.cell_voltage;
         gauge_port_pkg::A_VTS:   rd_data = regs_ff.discharge_threshold;
         gauge_port_pkg::A_CHARGE_COUNT_LOW:  rd_data = MEAS_I.charge_count_low;
         default:                 rd_data = 8'h00;
      endcase
   end

   // ==========================================================
   // writable registers; anything else is dropped silently
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         regs_ff <= '{charge_count_high: 8'h00, battery_ident: 8'h00, learned_capacity: 8'h00,
                      filter_threshold: gauge_port_pkg::DMF_RST, discharge_threshold: gauge_port_pkg::VTS_RST};
         srst_ff <= 1'b0;
      end else begin
         srst_ff <= 1'b0;
         if (wr_en) begin
            case (wr_addr)
               gauge_port_pkg::A_CHARGE_COUNT_HIGH:  regs_ff.charge_count_high  <= nxt_byte;
               gauge_port_pkg::A_BATTERY_IDENT: regs_ff.battery_ident <= nxt_byte;
               gauge_port_pkg::A_LMD:   regs_ff.learned_capacity   <= nxt_byte;
               gauge_port_pkg::A_DMF:   regs_ff.filter_threshold   <= nxt_byte;
               gauge_port_pkg::A_VTS:   regs_ff.discharge_threshold   <= nxt_byte;
               gauge_port_pkg::A_RST:   srst_ff <= nxt_byte[gauge_port_pkg::RST_BIT];
               default:                 ;
            endcase
         end
      end
   end

   // ==========================================================
   // primary flags
   assign flags   = {chg_ff, swap_ff, abs_ff, stale_ff, vdq_ff, 1'b0, first_empty_warning_ff, final_empty_warning_ff};
   assign raw_abs = EV_I.cell_hi | EV_I.cell_lo;
   assign vts_f   = (regs_ff.discharge_threshold > gauge_port_pkg::FINAL_EMPTY_WARNING_OF) ? regs_ff.discharge_threshold - gauge_port_pkg::FINAL_EMPTY_WARNING_OF : 8'h00;

   // charge activity, discharge wins
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         chg_ff <= 1'b0;
      end else begin
         chg_ff <= EV_I.chg_above & ~EV_I.dischg;
      end
   end

   // swap detect on cell crossings; set wins over clear
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         hi_ff   <= 1'b0;
         lo_ff   <= 1'b0;
         swap_ff <= 1'b1;
      end else begin
         hi_ff <= EV_I.cell_hi;
         lo_ff <= EV_I.cell_lo;
         if ((hi_ff & ~EV_I.cell_hi) | (lo_ff & ~EV_I.cell_lo) | srst_ff) begin
            swap_ff <= 1'b1;
         end else if (EV_I.valid_chg & (EV_I.full | first_empty_warning_ff)) begin
            swap_ff <= 1'b0;
         end
      end
   end

   // absent filter: raw level must hold for the filter window in ms ticks
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         ms_ff  <= 18'h00000;
         flt_ff <= 16'h0000;
         abs_ff <= 1'b0;
      end else begin
         ms_ff <= (ms_ff == 18'(MS_CYC - 1)) ? 18'h00000 : ms_ff + 18'h00001;
         if (raw_abs == abs_ff) begin
            flt_ff <= 16'h0000;
         end else if (ms_ff == 18'(MS_CYC - 1)) begin
            flt_ff <= flt_ff + 16'h0001;
            if (flt_ff == 16'(ABSENT_MS - 1)) begin
               abs_ff <= raw_abs;
               flt_ff <= 16'h0000;
            end
         end
      end
   end

   // charge counter since last capacity update, saturating
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         cpi_ff   <= 8'h00;
         stale_ff <= 1'b1;
      end else begin
         if (EV_I.lmd_upd) begin
            cpi_ff <= 8'h00;
         end else if (EV_I.valid_chg && cpi_ff != gauge_port_pkg::CPI_MAX) begin
            cpi_ff <= cpi_ff + 8'h01;
         end
         if (srst_ff || (EV_I.valid_chg && cpi_ff == gauge_port_pkg::CPI_LIM)) begin
            stale_ff <= 1'b1;
         end else if (EV_I.lmd_upd) begin
            stale_ff <= 1'b0;
         end
      end
   end

   // qualified discharge; armed by full count or charge done
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         from_full_ff <= 1'b0;
         vdq_ff       <= 1'b0;
      end else begin
         if (EV_I.full | EV_I.done) begin
            from_full_ff <= 1'b1;
         end else if (EV_I.dischg) begin
            from_full_ff <= 1'b0;
         end
         if (EV_I.dischg && from_full_ff) begin
            vdq_ff <= 1'b1;
         end else if (EV_I.lmd_upd | EV_I.self_discharge_count_max | EV_I.sustained
                      | (first_empty_warning_ff & EV_I.cold)) begin
            vdq_ff <= 1'b0;
         end
      end
   end

   // empty warnings latched until valid charge; a new trip wins
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         first_empty_warning_ff <= 1'b0;
         final_empty_warning_ff <= 1'b0;
      end else begin
         if (MEAS_I.cell_voltage < regs_ff.discharge_threshold) begin
            first_empty_warning_ff <= 1'b1;
         end else if (EV_I.valid_chg) begin
            first_empty_warning_ff <= 1'b0;
         end
         if (MEAS_I.cell_voltage < vts_f) begin
            final_empty_warning_ff <= 1'b1;
         end else if (EV_I.valid_chg) begin
            final_empty_warning_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign DQ_O          = zero_ff;
   assign DQ_OE_O       = oe_ff;
   assign REGS_O        = regs_ff;
   assign CPI_O         = cpi_ff;
   assign SOFT_RESET_O  = srst_ff;
   assign DISPLAY_OFF_O = final_empty_warning_ff;
   assign EMPTY_FLOAT_O = final_empty_warning_ff;
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         FLAGS_O <= 8'h00;
      end else begin
         FLAGS_O <= flags;
      end
   end

   // ==========================================================
   // assertions
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   chk_line_low_only: assert property (DQ_O == 1'b0)
      else $error("line driven high");
   chk_start_low: assert property (st_ff == L_TX && cnt_ff == '0 |=> DQ_OE_O)
      else $error("frame start not low");
   chk_zero_held: assert property (st_ff == L_TX && cnt_ff == C_DSU && !tx_ff[0] |=> DQ_OE_O)
      else $error("zero bit not held low");
   chk_stop_high: assert property (st_ff == L_TX && cnt_ff == C_SSU |=> !DQ_OE_O)
      else $error("line not released by stop time");
   chk_break_drop: assert property (st_ff == L_LOW && rise && is_break |=> bit_ff == 3'h0 && !data_ph_ff)
      else $error("break kept partial byte");
   chk_read_answer: assert property (byte_done && !data_ph_ff && !nxt_byte[7] |=> st_ff == L_GAP)
      else $error("read command not answered");
   chk_bad_write: assert property (wr_en && wr_addr == gauge_port_pkg::A_CMD |=> $stable(regs_ff) && !srst_ff)
      else $error("write to invalid address took effect");
   chk_charge_clear: assert property (EV_I.dischg |=> !chg_ff ##1 !FLAGS_O[7])
      else $error("charge flag survived discharge");
   chk_swap_reset: assert property (srst_ff |=> swap_ff && stale_ff)
      else $error("soft reset did not set flags");
   chk_stale_64: assert property (EV_I.valid_chg && cpi_ff == 8'h3f |=> stale_ff)
      else $error("stale flag missed 64th charge");
   chk_final_empty_warning_latch: assert property (final_empty_warning_ff && !EV_I.valid_chg |=> final_empty_warning_ff)
      else $error("final warning dropped without charge");

   cov_read_frame:  cover property (st_ff == L_TX && cnt_ff == C_BIT && bit_ff == 3'h7);
   cov_write_byte:  cover property (wr_en && wr_addr == gauge_port_pkg::A_VTS);
   cov_break_seen:  cover property (st_ff == L_LOW && rise && is_break);
   cov_soft_reset:  cover property (srst_ff);
endmodule

/* hdl/gauge_port_pkg.sv */
// constants, register map and carrier types for the single-wire gauge port
package gauge_port_pkg;
   // ==========================================================
   // clock and link timing (times in us except T_ABSENT_S in s, rate in bits/s)
   localparam int CLK_HZ     = 250_000_000;
   localparam int CLK_MHZ    = 250;
   localparam int BIT_RATE   = 333;
   localparam int T_START_US = 40;
   localparam int DATA_SETUP_TIME_US   = 100;
   localparam int T_DV_US    = 1000;
   localparam int T_SSU_US   = 2000;
   localparam int T_BREAK_US = 2500;
   localparam int T_BR_US    = 100;
   localparam int T_GAP_US   = 500;
   localparam int T_ABSENT_S = 30;
   // least times round up, frame period rounds up to honour the rate
   localparam int BIT_CYC    = (CLK_HZ + BIT_RATE - 1) / BIT_RATE;
   localparam int START_CYC  = T_START_US * CLK_MHZ;
   localparam int DSU_CYC    = DATA_SETUP_TIME_US * CLK_MHZ;
   localparam int DV_CYC     = (DATA_SETUP_TIME_US + T_DV_US) * CLK_MHZ;
   localparam int SSU_CYC    = T_SSU_US * CLK_MHZ;
   localparam int BREAK_CYC  = T_BREAK_US * CLK_MHZ;
   localparam int BR_CYC     = T_BR_US * CLK_MHZ;
   localparam int GAP_CYC    = T_GAP_US * CLK_MHZ;
   localparam int MS_CYC     = CLK_MHZ * 1000;
   localparam int ABSENT_MS  = T_ABSENT_S * 1000;
   // ==========================================================
   // register map
   localparam logic [6:0] A_CMD   = 7'h00;
   localparam logic [6:0] A_FLAGS = 7'h01;
   localparam logic [6:0] A_TEMPERATURE_AND_GAUGE = 7'h02;
   localparam logic [6:0] A_CHARGE_COUNT_HIGH  = 7'h03;
   localparam logic [6:0] A_BATTERY_IDENT = 7'h04;
   localparam logic [6:0] A_LMD   = 7'h05;
   localparam logic [6:0] A_SECONDARY_FLAGS = 7'h06;
   localparam logic [6:0] A_PPD   = 7'h07;
   localparam logic [6:0] A_PPU   = 7'h08;
   localparam logic [6:0] A_CPI   = 7'h09;
   localparam logic [6:0] A_DMF   = 7'h0a;
   localparam logic [6:0] A_VSB   = 7'h0b;
   localparam logic [6:0] A_VTS   = 7'h0c;
   localparam logic [6:0] A_CHARGE_COUNT_LOW  = 7'h17;
   localparam logic [6:0] A_RST   = 7'h39;
   localparam int         DIR_BIT = 7;
   localparam int         RST_BIT = 7;
   localparam logic [7:0] DMF_RST = 8'h96;
   localparam logic [7:0] VTS_RST = 8'h70;
   localparam logic [7:0] CPI_MAX = 8'hff;
   localparam logic [7:0] CPI_LIM = 8'h3f;   // 64th charge
   // final warning offset: 100 mV in 9.375 mV steps, rounded up
   localparam int         FINAL_EMPTY_WARNING_MV = 100;
   localparam int         LSB_UV  = 9375;
   localparam logic [7:0] FINAL_EMPTY_WARNING_OF = 8'((FINAL_EMPTY_WARNING_MV * 1000 + LSB_UV - 1) / LSB_UV);
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0] temperature_and_gauge;
      logic [7:0] secondary_flags;
      logic [7:0] prog_pin_pulldown;
      logic [7:0] prog_pin_pullup;
      logic [7:0] cell_voltage;
      logic [7:0] charge_count_low;
   } meas_t;
   typedef struct packed {
      logic cell_hi;     // cell above max cell voltage
      logic cell_lo;     // cell below 0.1 V
      logic chg_above;   // filtered sense voltage above charge threshold
      logic dischg;      // discharge activity
      logic full;        // count reached learned capacity
      logic done;        // charge done
      logic lmd_upd;     // learned capacity updated (pulse)
      logic valid_chg;   // valid charge action (pulse)
      logic self_discharge_count_max;    // self-discharge count reached 4096
      logic sustained;   // sustained valid charge
      logic cold;        // temperature below 0 C
   } ev_t;
   typedef struct packed {
      logic [7:0] charge_count_high;
      logic [7:0] battery_ident;
      logic [7:0] learned_capacity;
      logic [7:0] filter_threshold;
      logic [7:0] discharge_threshold;
   } regs_t;
endpackage

/* test/gauge_host_model.sv */
// host side model of the single-wire gauge line
`timescale 1ns/1ps
module gauge_host_model (
   // clock and line
   input  wire logic clk_i,
   input  wire logic dq_i,
   // open-drain pull
   output logic      pull_o
);
   // line released until the bench starts a frame
   initial pull_o = 1'b0;
   // pull or release for n cycles, changing just after an edge
   task automatic hold(input logic p, input int n);
      pull_o = p;
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // long low then recovery high
   task automatic brk();
      hold(1'b1, 120);
      hold(1'b0, 10);
   endtask
   // lsb first; a read skips the last pad so the answer is not missed
   task automatic send(input logic [7:0] b, input bit pad);
      for (int i = 0; i < 8; i++) begin
         hold(1'b1, b[i] ? 5 : 40);
         hold(1'b0, (i == 7 && !pad) ? 3 : (b[i] ? 195 : 160));
      end
   endtask
   // pulse-width capture, bounded waits
   task automatic recv(output logic [7:0] b, output bit ok);
      int t;
      int w;
      ok = 1;
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         t = 0;
         w = 0;
         while (dq_i === 1'b1 && t < 400) begin
            @(posedge clk_i);
            t++;
         end
         while (dq_i === 1'b0 && w < 400) begin
            @(posedge clk_i);
            w++;
         end
         if (t >= 400 || w >= 400) ok = 0;
         b[i] = (w < 20);
      end
   endtask
endmodule

/* test/tb_single_wire_gauge_register_port.sv */
// self-checking bench for the single-wire gauge register port
`timescale 1ns/1ps
module tb_single_wire_gauge_register_port;
   logic                  ref_clk = 1'b0;
   logic                  rst_n   = 1'b0;
   // shortened link timing so frames take a few hundred cycles
   localparam int BIT_C = 200, STA_C = 5, DSU_C = 10, DV_C = 40, SSU_C = 60;
   localparam int BRK_C = 100, BR_C = 5, GAP_C = 10, MS_C = 4, ABS_C = 3;
   logic                  dq, dq_o, dq_oe, pull, srst, disp, empt;
   logic [7:0]            inaccuracy_count;
   int                    srst_seen = 0;
   gauge_port_pkg::meas_t meas = '{8'h3c, 8'h00, 8'h21, 8'h12, 8'hff, 8'h5a};
   gauge_port_pkg::ev_t   ev   = '0;
   gauge_port_pkg::regs_t regs;
   logic [7:0]            flags, d;
   int                    errors = 0, samples_checked = 0;
   // wired-and line with host pull-up
   assign dq = ~(pull | (dq_oe & ~dq_o));
   initial forever #2 ref_clk = ~ref_clk;
   gauge_host_model HOST (.clk_i(ref_clk), .dq_i(dq), .pull_o(pull));
   single_wire_gauge_register_port #(.BIT_CYC(BIT_C), .START_CYC(STA_C), .DSU_CYC(DSU_C), .DV_CYC(DV_C),
      .SSU_CYC(SSU_C), .BREAK_CYC(BRK_C), .BR_CYC(BR_C), .GAP_CYC(GAP_C), .MS_CYC(MS_C), .ABSENT_MS(ABS_C)) DUT (
      .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .DQ_I(dq), .DQ_O(dq_o), .DQ_OE_O(dq_oe),
      .MEAS_I(meas), .EV_I(ev), .REGS_O(regs), .FLAGS_O(flags), .CPI_O(inaccuracy_count),
      .SOFT_RESET_O(srst), .DISPLAY_OFF_O(disp), .EMPTY_FLOAT_O(empt));
   // soft reset is a one-cycle pulse, so count it as it goes by
   always @(posedge ref_clk) if (srst === 1'b1) srst_seen++;
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      bit ok;
      HOST.brk();
      HOST.send({1'b0, a}, 0);
      HOST.recv(v, ok);
      if (!ok) v = 'x;
      HOST.hold(1'b0, 200);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      HOST.brk();
      HOST.send({1'b1, a}, 1);
      HOST.send(v, 1);
   endtask
   task automatic t_reset();
      check("regs", regs, {24'h0, 16'h9670});
      check("cpi disp empty", {inaccuracy_count, disp, empt}, 10'h000);
      check("flags", flags, 8'h50);
      rd(gauge_port_pkg::A_FLAGS, d);
      check("flags rd", d, 8'h50);
   endtask
   task automatic t_write_read();
      wr(gauge_port_pkg::A_VTS, 8'ha5);
      check("vts", regs.discharge_threshold, 8'ha5);
      rd(gauge_port_pkg::A_VTS, d);
      check("vts rd", d, 8'ha5);
      rd(gauge_port_pkg::A_VSB, d);
      check("vsb rd", d, 8'hff);
      rd(gauge_port_pkg::A_CMD, d);
      check("cmd rd", d, 8'h00);
   endtask
   task automatic t_ignored();
      wr(gauge_port_pkg::A_FLAGS, 8'h00);
      wr(7'h10, 8'h77);
      check("regs", regs, {24'h0, 16'h96a5});
      rd(gauge_port_pkg::A_FLAGS, d);
      check("flags rd", d, 8'h50);
   endtask
   task automatic t_abort();
      HOST.brk();
      HOST.send({1'b1, gauge_port_pkg::A_BATTERY_IDENT}, 1);
      wr(gauge_port_pkg::A_BATTERY_IDENT, 8'h5e);
      check("battery_ident", regs.battery_ident, 8'h5e);
   endtask
   task automatic t_charge();
      ev.chg_above = 1'b1;
      HOST.hold(1'b0, 4);
      check("chg on", flags[7], 1'b1);
      ev.dischg = 1'b1;
      HOST.hold(1'b0, 4);
      check("chg off", flags[7], 1'b0);
   endtask
   task automatic t_soft();
      wr(gauge_port_pkg::A_RST, 8'h80);
      HOST.hold(1'b0, 4);
      check("soft reset", srst_seen, 1);
      check("flags srst", flags[6], 1'b1);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence after 20 reset cycles
   initial begin
      repeat (20) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      HOST.hold(1'b0, 10);
      t_reset();
      t_write_read();
      t_ignored();
      t_abort();
      t_charge();
      t_soft();
      test_done();
   end
   // watchdog well above the expected 35000 cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      test_done();
   end
endmodule
